// ### hw/iplc_defines.vh
// Contract
// - field 00 off, 01/10/11 levels 0/1/2
// - these fields never select level three
// - all priority fields reset to zero
// - reserved bits read zero, ignore writes
// - offset 2: rx full, rx error fields
// - offset 2: tx idle, tx empty fields
// - offset 2: periph serial, port A fields
// - offset 3: converter A, timers 3, 2
// - offset 3: timers 1, 0, i2c address
// - offset 4: pwm fault, reload, zero-cross fields
// - offset 4 bits 1-0: converter B done
`ifndef IPLC_DEFINES_VH
`define IPLC_DEFINES_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define IPLC_IDX_SERIAL_PORT_A 4'h2
`define IPLC_IDX_TIMER_CONV 4'h3
`define IPLC_IDX_PWM_CONV 4'h4
`define IPLC_IDX_IRQ_STATUS 4'h8
`define IPLC_IDX_IRQ_MASK 4'h9
`define IPLC_IDX_REQ_LEVEL 4'hA

// ----------------------------------------
// writable bit masks and reset values
// ----------------------------------------
`define IPLC_MASK_SERIAL_PORT_A 16'hF3FF
`define IPLC_MASK_TIMER_CONV 16'hFFF0
`define IPLC_MASK_PWM_CONV 16'h00FF
`define IPLC_RESET_VALUE 16'h0000

// ----------------------------------------
// field positions: low bit of each 2-bit field
// ----------------------------------------
`define IPLC_POS_SERIAL_RX_FULL 4'hE
`define IPLC_POS_SERIAL_RX_ERROR 4'hC
`define IPLC_POS_SERIAL_TX_IDLE 4'h8
`define IPLC_POS_SERIAL_TX_EMPTY 4'h6
`define IPLC_POS_PERIPH_TX_EMPTY 4'h4
`define IPLC_POS_PERIPH_RX_FULL 4'h2
`define IPLC_POS_PORT_A 4'h0
`define IPLC_POS_CONVERTER_A_DONE 4'hE
`define IPLC_POS_TIMER_CH3 4'hC
`define IPLC_POS_TIMER_CH2 4'hA
`define IPLC_POS_TIMER_CH1 4'h8
`define IPLC_POS_TIMER_CH0 4'h6
`define IPLC_POS_I2C_ADDRESS 4'h4
`define IPLC_POS_PWM_FAULT 4'h6
`define IPLC_POS_PWM_RELOAD 4'h4
`define IPLC_POS_ZERO_CROSS_LIMIT 4'h2
`define IPLC_POS_CONVERTER_B_DONE 4'h0

// ----------------------------------------
// field encodings and source count
// ----------------------------------------
`define IPLC_FIELD_OFF 2'h0
`define IPLC_NUM_SRC 17
`define IPLC_EVT_WIDTH 2

`endif

// ### hw/iplc_field_decode.v
`default_nettype none

// one 2-bit field: decides whether a request goes on and at which level
module iplc_field_decode (
	// field and request
	input wire [1:0] field_i,
	input wire req_i,
	// decoded result
	output wire req_o,
	output wire [1:0] level_o
);

	// never level three: 11 maps to level 2
	// a disabled field yields level 0, so no slot ever carries three
	assign level_o = (field_i == 2'h0) ? 2'h0 : field_i - 2'h1;
	assign req_o = req_i & (field_i != 2'h0);

endmodule // iplc_field_decode

`default_nettype wire

// ### hw/iplc_top.v
// The Wishbone slave port was decided locally.
`include "iplc_defines.vh"
`default_nettype none

module iplc_top (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone classic slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg wb_err_o,
	// peripheral requests, bit order: see source index map
	input wire [16:0] src_req_i,
	// to the arbitration
	output reg [16:0] arb_req_o,
	output reg [33:0] arb_level_o,
	output reg [1:0] arb_top_level_o,
	output reg arb_any_o,
	// interrupt
	output wire irq_o
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [15:0] prio2_reg;
	reg [15:0] prio3_reg;
	reg [15:0] prio4_reg;
	reg [1:0] status_reg;
	reg [1:0] status_next;
	reg [1:0] mask_reg;
	reg [31:0] rdata;
	reg hit;
	reg prev_any_reg;
	reg prev_top_reg;
	reg [1:0] prev_lvl_reg;

	wire [3:0] idx = wb_adr_i[5:2];
	wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire wr = acc & wb_we_i & hit;
	wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [15:0] wdat = wb_dat_i[15:0];

	// ----------------------------------------
	// field gathering, source index map
	// ----------------------------------------
	// 0 rx full, 1 rx error, 2 tx idle, 3 tx empty, 4 periph tx empty,
	// 5 periph rx full, 6 port A, 7 converter A, 8..11 timer ch3..ch0,
	// 12 i2c address, 13 pwm fault, 14 pwm reload, 15 zero cross, 16 converter B
	wire [33:0] fields;
	assign fields[1:0] = prio2_reg[`IPLC_POS_SERIAL_RX_FULL +: 2];
	assign fields[3:2] = prio2_reg[`IPLC_POS_SERIAL_RX_ERROR +: 2];
	assign fields[5:4] = prio2_reg[`IPLC_POS_SERIAL_TX_IDLE +: 2];
	assign fields[7:6] = prio2_reg[`IPLC_POS_SERIAL_TX_EMPTY +: 2];
	assign fields[9:8] = prio2_reg[`IPLC_POS_PERIPH_TX_EMPTY +: 2];
	assign fields[11:10] = prio2_reg[`IPLC_POS_PERIPH_RX_FULL +: 2];
	assign fields[13:12] = prio2_reg[`IPLC_POS_PORT_A +: 2];
	assign fields[15:14] = prio3_reg[`IPLC_POS_CONVERTER_A_DONE +: 2];
	assign fields[17:16] = prio3_reg[`IPLC_POS_TIMER_CH3 +: 2];
	assign fields[19:18] = prio3_reg[`IPLC_POS_TIMER_CH2 +: 2];
	assign fields[21:20] = prio3_reg[`IPLC_POS_TIMER_CH1 +: 2];
	assign fields[23:22] = prio3_reg[`IPLC_POS_TIMER_CH0 +: 2];
	assign fields[25:24] = prio3_reg[`IPLC_POS_I2C_ADDRESS +: 2];
	assign fields[27:26] = prio4_reg[`IPLC_POS_PWM_FAULT +: 2];
	assign fields[29:28] = prio4_reg[`IPLC_POS_PWM_RELOAD +: 2];
	assign fields[31:30] = prio4_reg[`IPLC_POS_ZERO_CROSS_LIMIT +: 2];
	assign fields[33:32] = prio4_reg[`IPLC_POS_CONVERTER_B_DONE +: 2];

	// ----------------------------------------
	// request synchronisers and decode
	// ----------------------------------------
	// requests come from other logic but may be asynchronous; two stages
	reg [16:0] req_meta_reg;
	reg [16:0] req_sync_reg;
	wire [16:0] dec_req;
	wire [33:0] dec_lvl;

	always @(posedge clk_i) begin
		if (rst_i) begin
			req_meta_reg <= 17'h0_0000;
			req_sync_reg <= 17'h0_0000;
		end else begin
			req_meta_reg <= src_req_i;
			req_sync_reg <= req_meta_reg;
		end
	end

	// one decoder per source, in source index order
	iplc_field_decode u_serial_rx_full_level (
		.field_i(fields[1:0]),
		.req_i(req_sync_reg[0]),
		.req_o(dec_req[0]),
		.level_o(dec_lvl[1:0])
	);

	iplc_field_decode u_serial_rx_error_level (
		.field_i(fields[3:2]),
		.req_i(req_sync_reg[1]),
		.req_o(dec_req[1]),
		.level_o(dec_lvl[3:2])
	);

	iplc_field_decode u_serial_tx_idle_level (
		.field_i(fields[5:4]),
		.req_i(req_sync_reg[2]),
		.req_o(dec_req[2]),
		.level_o(dec_lvl[5:4])
	);

	iplc_field_decode u_serial_tx_empty_level (
		.field_i(fields[7:6]),
		.req_i(req_sync_reg[3]),
		.req_o(dec_req[3]),
		.level_o(dec_lvl[7:6])
	);

	iplc_field_decode u_periph_serial_tx_empty_level (
		.field_i(fields[9:8]),
		.req_i(req_sync_reg[4]),
		.req_o(dec_req[4]),
		.level_o(dec_lvl[9:8])
	);

	iplc_field_decode u_periph_serial_rx_full_level (
		.field_i(fields[11:10]),
		.req_i(req_sync_reg[5]),
		.req_o(dec_req[5]),
		.level_o(dec_lvl[11:10])
	);

	iplc_field_decode u_port_a_pin_event_level (
		.field_i(fields[13:12]),
		.req_i(req_sync_reg[6]),
		.req_o(dec_req[6]),
		.level_o(dec_lvl[13:12])
	);

	iplc_field_decode u_converter_a_done_level (
		.field_i(fields[15:14]),
		.req_i(req_sync_reg[7]),
		.req_o(dec_req[7]),
		.level_o(dec_lvl[15:14])
	);

	iplc_field_decode u_timer_ch3_level (
		.field_i(fields[17:16]),
		.req_i(req_sync_reg[8]),
		.req_o(dec_req[8]),
		.level_o(dec_lvl[17:16])
	);

	iplc_field_decode u_timer_ch2_level (
		.field_i(fields[19:18]),
		.req_i(req_sync_reg[9]),
		.req_o(dec_req[9]),
		.level_o(dec_lvl[19:18])
	);

	iplc_field_decode u_timer_ch1_level (
		.field_i(fields[21:20]),
		.req_i(req_sync_reg[10]),
		.req_o(dec_req[10]),
		.level_o(dec_lvl[21:20])
	);

	iplc_field_decode u_timer_ch0_level (
		.field_i(fields[23:22]),
		.req_i(req_sync_reg[11]),
		.req_o(dec_req[11]),
		.level_o(dec_lvl[23:22])
	);

	iplc_field_decode u_i2c_address_detect_level (
		.field_i(fields[25:24]),
		.req_i(req_sync_reg[12]),
		.req_o(dec_req[12]),
		.level_o(dec_lvl[25:24])
	);

	iplc_field_decode u_pwm_fault_level (
		.field_i(fields[27:26]),
		.req_i(req_sync_reg[13]),
		.req_o(dec_req[13]),
		.level_o(dec_lvl[27:26])
	);

	iplc_field_decode u_pwm_reload_level (
		.field_i(fields[29:28]),
		.req_i(req_sync_reg[14]),
		.req_o(dec_req[14]),
		.level_o(dec_lvl[29:28])
	);

	iplc_field_decode u_converter_zero_cross_limit_level (
		.field_i(fields[31:30]),
		.req_i(req_sync_reg[15]),
		.req_o(dec_req[15]),
		.level_o(dec_lvl[31:30])
	);

	iplc_field_decode u_converter_b_done_level (
		.field_i(fields[33:32]),
		.req_i(req_sync_reg[16]),
		.req_o(dec_req[16]),
		.level_o(dec_lvl[33:32])
	);

	// highest requested level among enabled, requesting sources
	reg [1:0] top_lvl;
	reg any_req;
	integer i;
	always @* begin
		top_lvl = 2'h0;
		any_req = 1'b0;
		for (i = 0; i < `IPLC_NUM_SRC; i = i + 1) begin
			if (dec_req[i]) begin
				any_req = 1'b1;
				if (dec_lvl[2*i+:2] > top_lvl) begin
					top_lvl = dec_lvl[2*i+:2];
				end
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			arb_req_o <= 17'h0_0000;
			arb_level_o <= 34'h0_0000_0000;
			arb_top_level_o <= 2'h0;
			arb_any_o <= 1'b0;
		end else begin
			arb_req_o <= dec_req;
			arb_level_o <= dec_lvl & fields_valid(dec_req);
			arb_top_level_o <= top_lvl;
			arb_any_o <= any_req;
		end
	end

	// spreads each request bit over its 2-bit level slot
	function [33:0] fields_valid;
		input [16:0] r;
		integer k;
		begin
			fields_valid = 34'h0_0000_0000;
			for (k = 0; k < 17; k = k + 1) begin
				fields_valid[2*k] = r[k];
				fields_valid[2*k+1] = r[k];
			end
		end
	endfunction

	// ----------------------------------------
	// wishbone decode and read mux
	// ----------------------------------------
	always @* begin
		hit = 1'b1;
		rdata = 32'h0000_0000;
		case (idx)
			`IPLC_IDX_SERIAL_PORT_A: rdata[15:0] = prio2_reg & `IPLC_MASK_SERIAL_PORT_A;
			`IPLC_IDX_TIMER_CONV: rdata[15:0] = prio3_reg & `IPLC_MASK_TIMER_CONV;
			`IPLC_IDX_PWM_CONV: rdata[15:0] = prio4_reg & `IPLC_MASK_PWM_CONV;
			`IPLC_IDX_IRQ_STATUS: rdata[1:0] = status_reg;
			`IPLC_IDX_IRQ_MASK: rdata[1:0] = mask_reg;
			`IPLC_IDX_REQ_LEVEL: rdata[2:0] = {arb_any_o, arb_top_level_o};
			default: hit = 1'b0;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= acc & hit;
			wb_err_o <= acc & ~hit;
			if (acc & hit & ~wb_we_i) begin
				wb_dat_o <= rdata;
			end
		end
	end

	// ----------------------------------------
	// priority registers
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			prio2_reg <= `IPLC_RESET_VALUE;
			prio3_reg <= `IPLC_RESET_VALUE;
			prio4_reg <= `IPLC_RESET_VALUE;
			mask_reg <= 2'h0;
		end else if (wr) begin
			if (idx == `IPLC_IDX_SERIAL_PORT_A) begin
				prio2_reg <= ((wdat & wmask) | (prio2_reg & ~wmask)) & `IPLC_MASK_SERIAL_PORT_A;
			end
			if (idx == `IPLC_IDX_TIMER_CONV) begin
				prio3_reg <= ((wdat & wmask) | (prio3_reg & ~wmask)) & `IPLC_MASK_TIMER_CONV;
			end
			if (idx == `IPLC_IDX_PWM_CONV) begin
				prio4_reg <= ((wdat & wmask) | (prio4_reg & ~wmask)) & `IPLC_MASK_PWM_CONV;
			end
			if (idx == `IPLC_IDX_IRQ_MASK && wb_sel_i[0]) begin
				mask_reg <= wb_dat_i[1:0];
			end
		end
	end

	// ----------------------------------------
	// interrupt status
	// ----------------------------------------
	// bit 0: a request appeared while none stood; bit 1: the top level rose while requests stood
	wire evt_new = arb_any_o & ~prev_any_reg;
	wire evt_rise = arb_any_o & prev_top_reg & (arb_top_level_o > prev_lvl_reg);

	always @* begin
		status_next = status_reg;
		if (wr && idx == `IPLC_IDX_IRQ_STATUS && wb_sel_i[0]) begin
			status_next = status_next & ~wb_dat_i[1:0];
		end
		// set wins over a clear in the same cycle
		status_next = status_next | {evt_rise, evt_new};
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= 2'h0;
			prev_any_reg <= 1'b0;
			prev_top_reg <= 1'b0;
			prev_lvl_reg <= 2'h0;
		end else begin
			status_reg <= status_next;
			prev_any_reg <= arb_any_o;
			prev_top_reg <= arb_any_o;
			prev_lvl_reg <= arb_top_level_o;
		end
	end

	assign irq_o = |(status_reg & mask_reg);

endmodule // iplc_top

`default_nettype wire

// ### dv/iplc_sva.sv
`default_nettype none
module iplc_sva (
	// clock, reset, bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	// requests
	input wire logic [16:0] src_req_i,
	input wire logic [16:0] arb_req_o,
	input wire logic [33:0] arb_level_o,
	input wire logic [1:0] arb_top_level_o,
	input wire logic arb_any_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// helper: any slot at three, and the highest slot level
	logic slot3;
	logic [1:0] slot_max;
	always_comb begin
		slot3 = 1'b0;
		slot_max = 2'h0;
		for (int k = 0; k < 17; k++) begin
			slot3 |= arb_level_o[2 * k +: 2] == 2'h3;
			if (arb_level_o[2 * k +: 2] > slot_max)
				slot_max = arb_level_o[2 * k +: 2];
		end
	end
	property p_hi_zero;
		wb_ack_o |-> wb_dat_o[31:16] == 16'h0000;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper half set");
	property p_no_l3;
		arb_top_level_o != 2'h3;
	endproperty
	a_no_l3: assert property (p_no_l3) else $error("level three");
	property p_quiet;
		!arb_any_o |-> arb_level_o == 34'h0 && arb_top_level_o == 2'h0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("level without request");
	property p_any;
		arb_any_o == (|arb_req_o);
	endproperty
	a_any: assert property (p_any) else $error("any flag wrong");
	property p_src;
		(arb_req_o & ~$past(src_req_i, 3)) == 17'h0_0000;
	endproperty
	a_src: assert property (p_src) else $error("request not raised");
	property p_ack_req;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack without request");
	property p_ack_one;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_err_ack;
		wb_err_o |-> !wb_ack_o;
	endproperty
	a_err_ack: assert property (p_err_ack) else $error("err with ack");
	property p_slot_l3;
		!slot3;
	endproperty
	a_slot_l3: assert property (p_slot_l3) else $error("slot at level three");
	property p_top_max;
		arb_top_level_o == slot_max;
	endproperty
	a_top_max: assert property (p_top_max) else $error("top level not highest");
	property p_rst_quiet;
		$fell(rst_i) |-> arb_req_o == 17'h0_0000 && !arb_any_o && !wb_ack_o;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("output set after reset");
endmodule // iplc_sva
bind iplc_top iplc_sva i_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
	.wb_err_o, .src_req_i, .arb_req_o, .arb_level_o, .arb_top_level_o, .arb_any_o);
`default_nettype wire

// ### dv/iplc_src_model.sv
`default_nettype none
module iplc_src_model (
	input wire logic clk_i,
	input wire logic [16:0] pat_i,
	output var logic [16:0] src_req_o = 17'h0_0000
);
	timeunit 1ns;
	timeprecision 1ps;
	// peripherals hold a request as a level
	always @(posedge clk_i) src_req_o <= pat_i;
endmodule // iplc_src_model
`default_nettype wire

// ### dv/irq_priority_level_config_tb_top.sv
`default_nettype none
module irq_priority_level_config_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [3:0] idx = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [16:0] pat = 17'h0_0000;
	logic [31:0] rdat, wv;
	logic ack, err, any, irq, es;
	logic [16:0] src, req, er;
	logic [33:0] lvl, el;
	logic [1:0] top, et, fc;
	logic [15:0] f[3];
	logic [31:0] exp_q[$];
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;
	int lo[17] = '{14, 12, 8, 6, 4, 2, 0, 14, 12, 10, 8, 6, 4, 6, 4, 2, 0};
	logic [15:0] msk[3] = '{16'hF3FF, 16'hFFF0, 16'h00FF};
	initial forever #2 clk_i = ~clk_i;
	iplc_top i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i({idx, 2'b00}), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .wb_err_o(err), .src_req_i(src), .arb_req_o(req),
		.arb_level_o(lvl), .arb_top_level_o(top), .arb_any_o(any), .irq_o(irq));
	iplc_src_model i_src (.clk_i, .pat_i(pat), .src_req_o(src));
	task automatic chk(string nm, logic [33:0] e, logic [33:0] s);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chk_read(logic [31:0] e, logic [31:0] s);
		chk("read", {2'b00, e}, {2'b00, s});
	endtask
	task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		idx <= a;
		wdat <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1 && err !== 1'b1);
		es = err;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(logic [3:0] a, logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask
	always @(posedge clk_i)
		if (ack === 1'b1 && we === 1'b0)
			chk_read(exp_q.pop_front(), rdat);
	task automatic give_verdict();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(32'h43d6));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int r = 0; r < 3; r++) begin
			rd(4'(r + 2), 0);
			bus(1'b1, 4'(r + 2), 32'hFFFF_FFFF);
			rd(4'(r + 2), msk[r]);
		end
		bus(1'b0, 4'h5, 0);
		chk("err", 1, es);
		repeat (12) begin
			for (int r = 0; r < 3; r++) begin
				wv = $urandom();
				f[r] = wv[15:0] & msk[r];
				bus(1'b1, 4'(r + 2), wv);
				rd(4'(r + 2), f[r]);
			end
			pat <= 17'($urandom());
			repeat (6) @(posedge clk_i);
			er = 0;
			el = 0;
			et = 0;
			for (int i = 0; i < 17; i++) begin
				fc = f[i < 7 ? 0 : i < 13 ? 1 : 2][lo[i] +: 2];
				if (pat[i] && fc != 2'b00) begin
					er[i] = 1'b1;
					el[2 * i +: 2] = fc - 2'b01;
					if (fc - 2'b01 > et)
						et = fc - 2'b01;
				end
			end
			chk("req", er, req);
			chk("level", el, lvl);
			chk("top", et, top);
		end
		bus(1'b1, 4'h9, 0);
		// every writable field at level 0
		for (int r = 0; r < 3; r++)
			bus(1'b1, 4'(r + 2), 32'h0000_5555);
		pat <= 17'h0_0000;
		repeat (6) @(posedge clk_i);
		bus(1'b1, 4'h8, 32'h0000_0003);
		pat <= 17'h1_FFFF;
		repeat (6) @(posedge clk_i);
		rd(4'h8, 32'h0000_0001);
		rd(4'hA, 32'h0000_0004);
		chk("irq masked", 0, irq);
		bus(1'b1, 4'h9, 32'h0000_0003);
		chk("irq", 1, irq);
		// raise seven sources to level 2 while requests stand
		bus(1'b1, 4'h2, 32'h0000_FFFF);
		rd(4'h8, 32'h0000_0003);
		rd(4'hA, 32'h0000_0006);
		bus(1'b1, 4'h8, 32'h0000_0003);
		chk("irq cleared", 0, irq);
		// reset in mid-run with requests still raised
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int r = 0; r < 3; r++)
			rd(4'(r + 2), 0);
		chk("req after reset", 0, req);
		chk("irq after reset", 0, irq);
		give_verdict();
	end
endmodule // irq_priority_level_config_tb_top
`default_nettype wire
